/* File: rtl/adc_ctrl.sv */
/*
  control logic of a sigma-delta converter: excitation enable, output
  coding, free running update timing, filter reset on sync and calibration.
  assumes the host drives control bits from its own logic on clock_i and
  the sync pin comes asynchronously from outside.
*/
`timescale 1ns/10ps
module adc_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int DATA_W_P = adc_ctrl_pkg::DATA_W,
  parameter int FREQ_W_P = adc_ctrl_pkg::FREQ_W
) (
  // clock, reset, enable
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                clk_en_i,
  // control bits from the host
  input  wire logic                excitation_enable_bit_i,
  input  wire logic                bipolar_i,
  input  wire logic [FREQ_W_P-1:0] notch_code_i,
  input  wire adc_ctrl_pkg::channel_t channel_i,
  input  wire logic                cal_cmd_i,
  // sync pin, active low, asynchronous
  input  wire logic                sync_n_i,
  // raw filter result
  input  wire logic [DATA_W_P-1:0] filter_result_i,
  // filter control
  output logic                     filter_reset_o,
  output logic                     mod_sample_o,
  // excitation outputs
  output logic                     excitation_out_a_o,
  output logic                     excitation_out_b_o,
  // output register
  output logic [DATA_W_P-1:0]      data_o,
  output logic                     update_o,
  output logic                     data_valid_o,
  output logic                     polarity_o
);
  import adc_ctrl_pkg::*;

  typedef struct packed {
    logic [2:0]          sync_sr;
    logic                sync_level;
    logic                exc;
    logic                bipolar;
    logic [MOD_DIV_W-1:0] mod_cnt;
    logic [FREQ_W_P+3:0] out_cnt;
    logic [2:0]          settle;
    logic                filt_rst;
    logic                mod_tick;
    logic                update;
    logic                valid;
    logic                pol;
    logic [DATA_W_P-1:0] data;
    conv_state_t         state;
  } state_t;

  state_t cur;
  state_t next_cur;

  logic [DATA_W_P-1:0] coded;
  logic                eff_bipolar;

  // period of one output in modulator samples, derived from notch code
  function automatic logic [FREQ_W_P+3:0] out_period(input logic [FREQ_W_P-1:0] code);
    logic [FREQ_W_P+3:0] p;
    p = {code, 4'h0};
    if (p == '0) begin
      p = {{(FREQ_W_P+3){1'b0}}, 1'b1};
    end
    return p;
  endfunction : out_period

  // high level channel ignores polarity
  assign eff_bipolar = cur.bipolar && (channel_i != CH_HIGH_LVL);

  output_coder #(
    .W (DATA_W_P)
  ) u_coder (
    .raw_i     (filter_result_i),
    .bipolar_i (eff_bipolar),
    .coded_o   (coded)
  );

  always_comb begin
    logic sync_fall;
    logic restart;
    sync_fall = 1'b0;
    restart   = 1'b0;
    next_cur  = cur;
    next_cur.mod_tick = 1'b0;
    next_cur.update   = 1'b0;
    next_cur.filt_rst = 1'b0;
    next_cur.sync_sr  = {cur.sync_sr[1:0], sync_n_i};
    // second and third stage must agree before a change counts
    if (cur.sync_sr[1] == cur.sync_sr[2] && cur.sync_sr[2] != cur.sync_level) begin
      next_cur.sync_level = cur.sync_sr[2];
      sync_fall = !cur.sync_sr[2];
    end
    next_cur.exc     = excitation_enable_bit_i;
    next_cur.bipolar = bipolar_i;
    restart = sync_fall || cal_cmd_i;
    if (restart) begin
      // counters restart from a fixed point so shared-clock parts align
      next_cur.mod_cnt  = '0;
      next_cur.out_cnt  = '0;
      next_cur.settle   = '0;
      next_cur.valid    = 1'b0;
      next_cur.filt_rst = 1'b1;
      next_cur.state    = ST_SETTLE;
    end else begin
      // sample tick every fixed number of master clocks
      if (cur.mod_cnt == MOD_DIV_W'(MOD_DIV - 1)) begin
        next_cur.mod_cnt  = '0;
        next_cur.mod_tick = 1'b1;
      end else begin
        next_cur.mod_cnt = cur.mod_cnt + 1'b1;
      end
      case (cur.state)
        ST_IDLE: begin
          next_cur.state = ST_SETTLE;
        end
        ST_RUN, ST_SETTLE: begin
          if (cur.mod_tick) begin
            if (cur.out_cnt >= out_period(notch_code_i) - 1'b1) begin
              next_cur.out_cnt = '0;
              next_cur.update  = 1'b1;
              next_cur.data    = coded;
              next_cur.pol     = eff_bipolar;
              if (cur.state == ST_SETTLE) begin
                if (cur.settle == SETTLE_CNT_W3 - 3'h1) begin
                  next_cur.valid = 1'b1;
                  next_cur.state = ST_RUN;
                end else begin
                  next_cur.settle = cur.settle + 3'h1;
                end
              end
            end else begin
              next_cur.out_cnt = cur.out_cnt + 1'b1;
            end
          end
        end
        default: next_cur.state = ST_SETTLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cur            <= '0;
      cur.sync_sr    <= 3'h7;
      cur.sync_level <= 1'b1;
      cur.exc        <= EXC_RESET;
      cur.bipolar    <= BIPOLAR_RESET;
      cur.state      <= ST_IDLE;
    end else if (clk_en_i) begin
      cur <= next_cur;
    end
  end

  assign excitation_out_a_o = cur.exc;
  assign excitation_out_b_o = cur.exc;
  assign filter_reset_o     = cur.filt_rst;
  assign mod_sample_o       = cur.mod_tick;
  assign data_o             = cur.data;
  assign update_o           = cur.update;
  assign data_valid_o       = cur.valid;
  assign polarity_o         = cur.pol;

  property p_exc_follow;
    @(posedge clock_i) disable iff (rst_i)
      clk_en_i |=> (excitation_out_a_o == $past(excitation_enable_bit_i))
                   && (excitation_out_b_o == excitation_out_a_o);
  endproperty
  a_exc_follow: assert property (p_exc_follow) else $error("excitation mismatch");

  property p_high_unipolar;
    @(posedge clock_i) disable iff (rst_i)
      (update_o && $past(clk_en_i) && $past(channel_i) == CH_HIGH_LVL) |-> !polarity_o;
  endproperty
  a_high_unipolar: assert property (p_high_unipolar) else $error("high level not unipolar");

  property p_cal_reset;
    @(posedge clock_i) disable iff (rst_i)
      (cal_cmd_i && clk_en_i) |=> filter_reset_o && !data_valid_o;
  endproperty
  a_cal_reset: assert property (p_cal_reset) else $error("calibration did not reset filter");

  property p_sync_reset;
    @(posedge clock_i) disable iff (rst_i)
      (clk_en_i && cur.sync_sr[1] == cur.sync_sr[2] && !cur.sync_sr[2] && cur.sync_level)
        |=> filter_reset_o && cur.mod_cnt == '0;
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync edge did not reset");

  property p_update_data;
    @(posedge clock_i) disable iff (rst_i)
      update_o |-> data_o == $past(coded);
  endproperty
  a_update_data: assert property (p_update_data) else $error("update data wrong");

  property p_stable_data;
    @(posedge clock_i) disable iff (rst_i)
      !update_o |-> $stable(data_o);
  endproperty
  a_stable_data: assert property (p_stable_data) else $error("data changed without update");

  property p_tick_spacing;
    @(posedge clock_i) disable iff (rst_i)
      (mod_sample_o && clk_en_i) |=> !mod_sample_o [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("sample ticks too close");

  property p_update_on_tick;
    @(posedge clock_i) disable iff (rst_i)
      (update_o && $past(clk_en_i)) |-> $past(mod_sample_o);
  endproperty
  a_update_on_tick: assert property (p_update_on_tick) else $error("update off tick");

  property p_reset_vals;
    @(posedge clock_i) $past(rst_i) |-> !excitation_out_a_o && !excitation_out_b_o
      && !cur.bipolar && !update_o && !data_valid_o && !filter_reset_o && data_o == '0;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

  // a low enable must hold every output, otherwise rates would not scale with it
  property p_freeze_hold;
    @(posedge clock_i) disable iff (rst_i)
      !clk_en_i |=> $stable(data_o) && $stable(update_o) && $stable(data_valid_o)
                    && $stable(filter_reset_o) && $stable(mod_sample_o)
                    && $stable(excitation_out_a_o) && $stable(polarity_o);
  endproperty
  a_freeze_hold: assert property (p_freeze_hold) else $error("state moved while disabled");

  property p_pol_diff;
    @(posedge clock_i) disable iff (rst_i)
      (update_o && $past(clk_en_i) && $past(channel_i) != CH_HIGH_LVL)
        |-> polarity_o == $past(cur.bipolar);
  endproperty
  a_pol_diff: assert property (p_pol_diff) else $error("channel coding not shared");

  property p_bip_code;
    @(posedge clock_i) disable iff (rst_i)
      (update_o && $past(clk_en_i) && polarity_o)
        |-> data_o == ($past(filter_result_i) ^ {1'b1, {(DATA_W_P-1){1'b0}}});
  endproperty
  a_bip_code: assert property (p_bip_code) else $error("offset binary coding wrong");

  property p_uni_code;
    @(posedge clock_i) disable iff (rst_i)
      (update_o && $past(clk_en_i) && !polarity_o)
        |-> data_o == ($past(filter_result_i[DATA_W_P-1]) ? {DATA_W_P{1'b0}}
                       : {$past(filter_result_i[DATA_W_P-2:0]), 1'b0});
  endproperty
  a_uni_code: assert property (p_uni_code) else $error("straight binary coding wrong");

  property p_filt_clear;
    @(posedge clock_i) disable iff (rst_i)
      filter_reset_o |-> !data_valid_o && !update_o;
  endproperty
  a_filt_clear: assert property (p_filt_clear) else $error("valid kept over restart");

  property p_valid_on_update;
    @(posedge clock_i) disable iff (rst_i)
      $rose(data_valid_o) |-> update_o;
  endproperty
  a_valid_on_update: assert property (p_valid_on_update) else $error("valid off update");

  property p_restart_counters;
    @(posedge clock_i) disable iff (rst_i)
      (cal_cmd_i && clk_en_i) |=> cur.mod_cnt == '0 && cur.out_cnt == '0
                                 && !mod_sample_o && !update_o;
  endproperty
  a_restart_counters: assert property (p_restart_counters) else $error("timing not restarted");

  property p_idle_leave;
    @(posedge clock_i) disable iff (rst_i)
      (cur.state == ST_IDLE && clk_en_i) |=> cur.state == ST_SETTLE;
  endproperty
  a_idle_leave: assert property (p_idle_leave) else $error("conversion did not start");

  property p_valid_run;
    @(posedge clock_i) disable iff (rst_i)
      data_valid_o == (cur.state == ST_RUN);
  endproperty
  a_valid_run: assert property (p_valid_run) else $error("valid and state disagree");

  property p_update_count;
    @(posedge clock_i) disable iff (rst_i)
      update_o |-> cur.out_cnt == '0;
  endproperty
  a_update_count: assert property (p_update_count) else $error("update mid period");

  property p_settle_bound;
    @(posedge clock_i) disable iff (rst_i)
      (cur.state == ST_SETTLE) |-> cur.settle < SETTLE_CNT_W3;
  endproperty
  a_settle_bound: assert property (p_settle_bound) else $error("settle count overrun");

  // a pin change only counts once the last two stages agree
  property p_sync_agree;
    @(posedge clock_i) disable iff (rst_i)
      (clk_en_i && cur.sync_sr[2] != cur.sync_sr[1]) |=> $stable(cur.sync_level);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync level moved early");
endmodule : adc_ctrl

/* File: rtl/adc_ctrl_pkg.sv */
/*
  shared constants for the converter control block: widths, output coding
  and rate derivation counts.
  assumes a single 40 MHz system clock standing in for the master clock.
*/
package adc_ctrl_pkg;
  localparam int          DATA_W         = 24;
  localparam int          FREQ_W         = 12;
  // master clock period in ns as given
  localparam int          CLK_PERIOD_NS  = 25;
  // modulator sample period: 256 master clocks per sample
  localparam int          MOD_DIV        = 256;
  localparam int          MOD_DIV_W      = 8;
  // output periods after a restart before data counts as valid
  localparam int          SETTLE_PERIODS = 4;
  localparam logic [2:0]  SETTLE_CNT_W3  = 3'h4;
  localparam logic [11:0] NOTCH_RESET    = 12'h0C3;
  localparam logic        EXC_RESET      = 1'b0;
  localparam logic        BIPOLAR_RESET  = 1'b0;
  localparam logic [23:0] MID_SCALE      = 24'h800000;

  typedef enum logic [1:0] {
    CH_DIFF_ONE  = 2'h0,
    CH_DIFF_TWO  = 2'h1,
    CH_HIGH_LVL  = 2'h2
  } channel_t;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h1,
    ST_RUN      = 3'h2,
    ST_SETTLE   = 3'h4
  } conv_state_t;
endpackage : adc_ctrl_pkg

/* File: rtl/output_coder.sv */
/*
  output coder: turns a raw two's complement filter result into the
  selected output coding.
  assumes the result is a signed value centred on zero.
*/
`timescale 1ns/10ps
module output_coder #(
  parameter int W = 24
) (
  // raw result and coding select
  input  wire logic [W-1:0] raw_i,
  input  wire logic         bipolar_i,
  // coded result
  output logic      [W-1:0] coded_o
);
  import adc_ctrl_pkg::*;

  // unipolar: negative results clamp to zero, straight binary otherwise
  // bipolar: offset binary, i.e. msb inverted
  always_comb begin
    if (bipolar_i) begin
      coded_o = raw_i ^ {1'b1, {(W-1){1'b0}}};
    end else if (raw_i[W-1]) begin
      coded_o = '0;
    end else begin
      coded_o = {raw_i[W-2:0], 1'b0};
    end
  end
endmodule : output_coder

/* File: testbench/host_model.sv */
/*
  host model: holds the sync pin high and pulses it low on request.
  assumes requests come from the bench, one clock wide, off the rising edge.
*/
`timescale 1ns/10ps
module host_model (
  // clock and request
  input  wire logic clock_i,
  input  wire logic sync_req_i,
  // sync pin, active low
  output logic      sync_n_o
);
  logic [2:0] low_cnt = 3'h0;
  logic       pin_lvl = 1'b1;
  assign sync_n_o = pin_lvl;
  // requested only after reset with defaults or after a calibration ends
  always @(posedge clock_i) begin
    if (sync_req_i) begin
      low_cnt <= 3'h4;
      pin_lvl <= 1'b0;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
      pin_lvl <= (low_cnt == 3'h1);
    end
  end
endmodule : host_model

/* File: testbench/tb_top.sv */
/*
  self-checking bench for the converter control block.
  assumes notch code 1, so one output period is 16 ticks of 256 clocks.
*/
`timescale 1ns/10ps
module tb_top;
  import adc_ctrl_pkg::*;
  logic        clock_i, rst_i, clk_en_i, exc, bip, cal, sync_req, sync_n;
  logic [11:0] notch;
  channel_t    ch;
  logic [23:0] raw;
  logic        f_rst, tick, exa, exb, upd, valid, pol;
  logic [23:0] data;
  int          errors, total_checks, n, c1;
  adc_ctrl dut (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(clk_en_i),
    .excitation_enable_bit_i(exc), .bipolar_i(bip), .notch_code_i(notch),
    .channel_i(ch), .cal_cmd_i(cal), .sync_n_i(sync_n), .filter_result_i(raw),
    .filter_reset_o(f_rst), .mod_sample_o(tick), .excitation_out_a_o(exa),
    .excitation_out_b_o(exb), .data_o(data), .update_o(upd),
    .data_valid_o(valid), .polarity_o(pol));
  host_model host (.clock_i(clock_i), .sync_req_i(sync_req), .sync_n_o(sync_n));
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  function automatic logic [23:0] coded(input logic [23:0] r, input logic b, input channel_t c);
    if (b && c != CH_HIGH_LVL) return r ^ MID_SCALE;
    return r[23] ? 24'h000000 : {r[22:0], 1'b0};
  endfunction : coded
  // counts falling edges up to the next rising of update_o; half toggles clk_en_i
  task automatic wait_upd(input bit half, output int cnt);
    logic p;
    p   = upd;
    cnt = 0;
    while (!(upd === 1'b1 && !p)) begin
      p = upd;
      @(negedge clock_i);
      if (half) clk_en_i = ~clk_en_i;
      cnt++;
      if (cnt > 10000) begin
        errors++;
        close_out();
      end
    end
  endtask : wait_upd
  task automatic wait_frst(input int lim);
    int k;
    for (k = 0; k < lim && f_rst !== 1'b1; k++) @(negedge clock_i);
    chk("filter_reset", {23'h0, f_rst}, 24'h000001);
  endtask : wait_frst
  task automatic do_sync();
    sync_req = 1'b1;
    @(negedge clock_i);
    sync_req = 1'b0;
    wait_frst(12);
  endtask : do_sync
  initial begin
    {rst_i, clk_en_i, exc, bip, cal, sync_req} = 6'h38;
    notch = 12'h001;
    ch    = CH_DIFF_ONE;
    raw   = 24'h000000;
    n     = $urandom(32'hF7A9);
    repeat (16) @(negedge clock_i);
    // excitation requested during reset must not reach the outputs
    chk("exc_reset", {22'h0, exa, exb}, 24'h000000);
    chk("pol_reset", {23'h0, pol}, 24'h000000);
    chk("valid_reset", {22'h0, valid, upd}, 24'h000000);
    exc   = 1'b0;
    rst_i = 1'b0;
    @(negedge clock_i);
    do_sync();
    for (int v = 1; v >= 0; v--) begin
      exc = v[0];
      @(negedge clock_i);
      chk("exc", {22'h0, exa, exb}, {22'h0, v[0], v[0]});
    end
    for (int i = 0; i < 7; i++) begin
      raw = (i == 0) ? 24'h7FFFFF : (i == 1) ? 24'h800000 : 24'($urandom);
      bip = (i < 2) ? i[0] : 1'($urandom);
      ch  = channel_t'(i % 3);
      wait_upd(1'b0, n);
      chk("data", data, coded(raw, bip, ch));
      chk("polarity", {23'h0, pol}, {23'h0, bip && ch != CH_HIGH_LVL});
      chk("valid", {23'h0, valid}, {23'h0, i >= 3});
      if (i > 0) chk("period", 24'(n), 24'd4096);
    end
    cal = 1'b1;
    @(negedge clock_i);
    cal = 1'b0;
    wait_frst(1);
    chk("valid_cal", {23'h0, valid}, 24'h000000);
    for (n = 0; n < 300 && tick !== 1'b1; n++) @(negedge clock_i);
    chk("tick_delay", 24'(n), 24'(MOD_DIV));
    wait_upd(1'b0, c1);
    c1 += n;
    chk("cal_phase", 24'(c1), 24'(MOD_DIV * 16 + 1));
    do_sync();
    wait_upd(1'b0, n);
    chk("sync_phase", 24'(n), 24'(c1));
    wait_upd(1'b1, n);
    wait_upd(1'b1, n);
    chk("half_rate", 24'(n), 24'd8192);
    clk_en_i = 1'b1;
    close_out();
  end
endmodule : tb_top
